// ===== dv/scu_host.sv
`timescale 1ns/100ps
module scu_host (
  // clock
  input  wire logic       i_clk,
  // requests to the register port
  output logic            o_instr_vld,
  output logic [9:0]      o_instr_addr,
  output logic            o_wr_en,
  output logic [7:0]      o_wr_data,
  output logic            o_rd_en,
  // read answer
  input  wire logic [7:0] i_rd_data
);
  // ****
  // host side
  // ****
  // idle lines carry junk, never the last value
  initial begin
    o_instr_vld  = 1'b0;
    o_instr_addr = 10'h3FF;
    o_wr_en      = 1'b0;
    o_wr_data    = 8'hA5;
    o_rd_en      = 1'b0;
  end
  // config byte: mirrored, length bit kept at one
  function automatic logic [7:0] cfg(input logic [3:0] n);
    cfg = {n[0], n[1], n[2], 1'b1, 1'b1, n[2], n[1], n[0]};
  endfunction
  // instruction, then n bytes back to back, first in d[15:8]
  task automatic wr(input logic [9:0] a, input int n, input logic [15:0] d);
    @(posedge i_clk);
    o_instr_vld  <= 1'b1;
    o_instr_addr <= a;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      o_instr_vld <= 1'b0;
      o_wr_en     <= 1'b1;
      o_wr_data   <= d[15-8*k -: 8];
    end
    @(posedge i_clk);
    o_wr_en      <= 1'b0;
    o_wr_data    <= ~d[7:0];
    o_instr_addr <= ~a;
  endtask
  // single byte read, answer lands one cycle after the request
  task automatic rd(input logic [9:0] a, output logic [7:0] q);
    @(posedge i_clk);
    o_instr_vld  <= 1'b1;
    o_instr_addr <= a;
    @(posedge i_clk);
    o_instr_vld <= 1'b0;
    o_rd_en     <= 1'b1;
    @(posedge i_clk);
    o_rd_en      <= 1'b0;
    o_instr_addr <= ~a;
    #1 q = i_rd_data;
  endtask
endmodule // scu_host

// ===== dv/serial_port_config_update_regs_tb.sv
`timescale 1ns/100ps
module serial_port_config_update_regs_tb;
  logic         i_clk = 1'b0;
  logic         i_sys_rst = 1'b1;
  logic         instr_vld, wr_en, rd_en, rd_vld, upd_done;
  logic         long_instr, soft_rst, lsb_first, pin_en;
  logic [9:0]   instr_addr;
  logic [7:0]   wr_data, rd_data, q;
  logic [127:0] active;
  int           err_count = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  int           n;
  // ****
  // harness
  // ****
  always #25 i_clk = ~i_clk;
  scu_regs u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_instr_vld(instr_vld), .i_instr_addr(instr_addr), .i_wr_en(wr_en),
    .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .o_rd_vld(rd_vld), .o_long_instr(long_instr), .o_soft_rst(soft_rst),
    .o_lsb_first(lsb_first), .o_serial_read_out_pin_en(pin_en),
    .o_active(active), .o_upd_done(upd_done));
  scu_host u_host (.i_clk(i_clk), .o_instr_vld(instr_vld),
    .o_instr_addr(instr_addr), .o_wr_en(wr_en), .o_wr_data(wr_data),
    .o_rd_en(rd_en), .i_rd_data(rd_data));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, far above the hundred or so cycles needed
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    check(long_instr, 1'b1);
    check({soft_rst, lsb_first, pin_en}, 3'h0);
    check(active, 128'h0);
    $display("reset test done");
    // every order and pin mode, readback same in both orders
    for (int k = 8; k < 12; k++) begin
      u_host.wr(10'h000, 1, {u_host.cfg(k[3:0]), 8'h00});
      #1;
      check({long_instr, lsb_first, pin_en}, {1'b1, k[1:0]});
      u_host.rd(10'h000, q);
      check(q, u_host.cfg(k[3:0]));
    end
    $display("config test done");
    // lsb first: wire bytes reversed, address climbs
    u_host.wr(10'h010, 2, {8'h48, 8'h2C});
    u_host.wr(10'h000, 1, {u_host.cfg(4'h8), 8'h00});
    // msb first: address falls
    u_host.wr(10'h013, 2, {8'h56, 8'h78});
    #1;
    check(active, 128'h0);
    u_host.wr(10'h232, 1, {8'h01, 8'h00});
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (upd_done !== 1'b1 && n < 8);
    check(n < 8, 1'b1);
    check(active, {96'h0, 32'h56783412});
    u_host.rd(10'h232, q);
    check(q, 8'h00);
    // buffer read back in msb order, then reversed in lsb order
    u_host.rd(10'h010, q);
    check(q, 8'h12);
    check(rd_vld, 1'b1);
    $display("update test done");
    // soft reset from lsb mode, writes refused while held
    u_host.wr(10'h000, 1, {u_host.cfg(4'hA), 8'h00});
    u_host.rd(10'h011, q);
    check(q, 8'h2C);
    u_host.wr(10'h000, 1, {u_host.cfg(4'hC), 8'h00});
    #1;
    check({soft_rst, lsb_first, long_instr}, 3'b101);
    check(active, 128'h0);
    u_host.wr(10'h010, 1, {8'h77, 8'h00});
    u_host.wr(10'h232, 1, {8'h01, 8'h00});
    // a refused strobe must never produce the done pulse
    @(posedge i_clk);
    #1;
    check(upd_done, 1'b0);
    repeat (6) @(posedge i_clk);
    #1;
    check(soft_rst, 1'b1);
    check(active, 128'h0);
    u_host.wr(10'h000, 1, {u_host.cfg(4'h8), 8'h00});
    #1;
    check(soft_rst, 1'b0);
    u_host.rd(10'h010, q);
    check(q, 8'h00);
    u_host.rd(10'h100, q);
    check(q, 8'h00);
    $display("soft reset test done");
    final_report();
  end
endmodule // serial_port_config_update_regs_tb

// ===== hdl/scu_pkg.sv
package scu_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam int          ADDR_W        = 10;
  localparam logic [9:0]  ADDR_CFG      = 10'h000;
  localparam logic [9:0]  ADDR_UPD      = 10'h232;
  localparam logic [9:0]  ADDR_BUF_BASE = 10'h010;
  localparam int          BUF_COUNT     = 16;
  localparam logic [9:0]  BUF_COUNT_A   = 10'h010;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_READ_PIN = 0;
  localparam int BIT_LSB      = 1;
  localparam int BIT_SRST     = 2;
  localparam int BIT_LONG     = 3;
  localparam int BIT_UPD      = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] CFG_RST = 4'h8;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] UPD_RST = 8'h00;

  // bit reversal of one byte, used on the way in and out
  function automatic logic [7:0] rev8(input logic [7:0] b);
    rev8 = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction

  // readback form of the config nibble, upper half mirrored
  function automatic logic [7:0] mirror(input logic [3:0] n);
    mirror = {n[0], n[1], n[2], n[3], n};
  endfunction

endpackage

// ===== hdl/scu_regs.sv
`timescale 1ns/100ps
module scu_regs (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  // instruction phase from the serial shifter
  input  wire logic                       i_instr_vld,
  input  wire logic [scu_pkg::ADDR_W-1:0] i_instr_addr,
  // data bytes from and to the serial shifter
  input  wire logic                       i_wr_en,
  input  wire logic [7:0]                 i_wr_data,
  input  wire logic                       i_rd_en,
  output logic      [7:0]                 o_rd_data,
  output logic                            o_rd_vld,
  // port configuration outputs
  output logic                            o_long_instr,
  output logic                            o_soft_rst,
  output logic                            o_lsb_first,
  output logic                            o_serial_read_out_pin_en,
  // committed register image
  output logic      [8*scu_pkg::BUF_COUNT-1:0] o_active,
  output logic                            o_upd_done
);

  // ****************************************
  // address tracking
  // ****************************************
  logic [scu_pkg::ADDR_W-1:0] addr_cur;
  logic                       upd_pend;
  logic [7:0]                 buf_mem [scu_pkg::BUF_COUNT];

  wire                        byte_go   = i_wr_en | i_rd_en;
  wire [scu_pkg::ADDR_W-1:0]  addr_use  = i_instr_vld ? i_instr_addr
                                                      : addr_cur;
  // msb first walks down the map, lsb first walks up
  wire [scu_pkg::ADDR_W-1:0]  next_addr = o_lsb_first ? addr_use + 10'h001
                                                      : addr_use - 10'h001;

  // current byte address, stepped once per data byte
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      addr_cur <= '0;
    end else if (byte_go) begin
      addr_cur <= next_addr;
    end else if (i_instr_vld) begin
      addr_cur <= i_instr_addr;
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  // shifter hands bytes in wire order; undo lsb-first reversal here
  wire [7:0] wr_byte   = o_lsb_first ? scu_pkg::rev8(i_wr_data)
                                     : i_wr_data;
  wire       cfg_hit   = addr_use == scu_pkg::ADDR_CFG;
  wire       upd_hit   = addr_use == scu_pkg::ADDR_UPD;
  wire [9:0] buf_off   = addr_use - scu_pkg::ADDR_BUF_BASE;
  wire       buf_hit   = buf_off < scu_pkg::BUF_COUNT_A;
  wire [3:0] buf_idx   = buf_off[3:0];
  wire       cfg_wr    = i_wr_en & cfg_hit;
  // only the low nibble is decoded; the mirrored half is redundant
  wire [3:0] cfg_nib   = wr_byte[3:0];
  wire       srst_next = cfg_nib[scu_pkg::BIT_SRST];
  // the write that clears soft reset still leaves fields at default
  wire       cfg_hold  = o_soft_rst | srst_next;
  wire       soft_hold = o_soft_rst | (cfg_wr & srst_next);
  wire       upd_wr    = i_wr_en & upd_hit & wr_byte[scu_pkg::BIT_UPD];
  wire       buf_wr    = i_wr_en & buf_hit & ~soft_hold;

  // ****************************************
  // port configuration register
  // ****************************************
  // soft reset bit is cleared only by a host write or by system reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_long_instr             <= scu_pkg::CFG_RST[scu_pkg::BIT_LONG];
      o_soft_rst               <= scu_pkg::CFG_RST[scu_pkg::BIT_SRST];
      o_lsb_first              <= scu_pkg::CFG_RST[scu_pkg::BIT_LSB];
      o_serial_read_out_pin_en <= scu_pkg::CFG_RST[scu_pkg::BIT_READ_PIN];
    end else if (cfg_wr) begin
      o_soft_rst <= srst_next;
      if (cfg_hold) begin
        o_long_instr             <= scu_pkg::CFG_RST[scu_pkg::BIT_LONG];
        o_lsb_first              <= scu_pkg::CFG_RST[scu_pkg::BIT_LSB];
        o_serial_read_out_pin_en <= scu_pkg::CFG_RST[scu_pkg::BIT_READ_PIN];
      end else begin
        o_long_instr             <= cfg_nib[scu_pkg::BIT_LONG];
        o_lsb_first              <= cfg_nib[scu_pkg::BIT_LSB];
        o_serial_read_out_pin_en <= cfg_nib[scu_pkg::BIT_READ_PIN];
      end
    end
  end

  // ****************************************
  // update strobe and buffered registers
  // ****************************************
  // strobe reads back as one for the single cycle before the copy
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || soft_hold) begin
      upd_pend   <= scu_pkg::UPD_RST[scu_pkg::BIT_UPD];
      o_upd_done <= 1'b0;
    end else begin
      upd_pend   <= upd_wr;
      o_upd_done <= upd_pend;
    end
  end

  // buffers take host writes; active copy moves only on the strobe, and is cleared by system or soft reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || soft_hold) begin
      for (int i = 0; i < scu_pkg::BUF_COUNT; i++) begin
        buf_mem[i]         <= scu_pkg::BUF_RST;
        o_active[8*i +: 8] <= scu_pkg::BUF_RST;
      end
    end else begin
      if (buf_wr) begin
        buf_mem[buf_idx] <= wr_byte;
      end
      if (upd_pend) begin
        for (int i = 0; i < scu_pkg::BUF_COUNT; i++) begin
          o_active[8*i +: 8] <= buf_mem[i];
        end
      end
    end
  end

  // ****************************************
  // readback
  // ****************************************
  wire [3:0] cfg_now = {o_long_instr, o_soft_rst, o_lsb_first,
                        o_serial_read_out_pin_en};
  wire [7:0] rd_val  = cfg_hit ? scu_pkg::mirror(cfg_now)
                     : upd_hit ? {7'h00, upd_pend}
                     : buf_hit ? buf_mem[buf_idx]
                     : 8'h00;
  // readback shows buffers, never the committed image
  wire [7:0] rd_wire = o_lsb_first ? scu_pkg::rev8(rd_val) : rd_val;

  // read byte presented one cycle after the request, in wire order
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
      o_rd_vld  <= 1'b0;
    end else begin
      o_rd_vld <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_wire;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [8*scu_pkg::BUF_COUNT-1:0] buf_flat;
  always_comb begin
    for (int i = 0; i < scu_pkg::BUF_COUNT; i++) begin
      buf_flat[8*i +: 8] = buf_mem[i];
    end
  end
  wire raw_mirrored = i_wr_data == scu_pkg::rev8(i_wr_data);

  property p_upd_set;
    @(posedge i_clk) disable iff (i_sys_rst)
      upd_wr && !soft_hold |=> upd_pend ##1 o_upd_done;
  endproperty
  a_upd_set: assert property (p_upd_set)
    else $error("update strobe not seen");

  property p_upd_selfclr;
    @(posedge i_clk) disable iff (i_sys_rst)
      upd_pend && !upd_wr |=> !upd_pend;
  endproperty
  a_upd_selfclr: assert property (p_upd_selfclr)
    else $error("update bit did not clear");

  property p_copy;
    @(posedge i_clk) disable iff (i_sys_rst)
      upd_pend && !soft_hold |=> o_active == $past(buf_flat);
  endproperty
  a_copy: assert property (p_copy)
    else $error("active image differs from buffers");

  property p_mirror;
    @(posedge i_clk) disable iff (i_sys_rst)
      cfg_wr && !cfg_hold && raw_mirrored |=>
        o_lsb_first == $past(i_wr_data[1]) &&
        o_long_instr == $past(i_wr_data[3]);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirrored config decoded by order");

  property p_defaults;
    @(posedge i_clk) disable iff (i_sys_rst)
      $past(i_sys_rst) |-> o_long_instr && !o_soft_rst && !o_lsb_first
        && !o_serial_read_out_pin_en;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("config defaults wrong after reset");

  property p_srst_enter;
    @(posedge i_clk) disable iff (i_sys_rst)
      cfg_wr && srst_next |=> o_soft_rst && o_long_instr && !o_lsb_first
        && o_active == '0 && !upd_pend;
  endproperty
  a_srst_enter: assert property (p_srst_enter)
    else $error("soft reset did not restore defaults");

  property p_srst_stay;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_soft_rst && !cfg_wr |=> o_soft_rst;
  endproperty
  a_srst_stay: assert property (p_srst_stay)
    else $error("soft reset cleared by itself");

  property p_srst_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_soft_rst && i_wr_en |=> o_active == '0 && buf_flat == '0
        && !o_lsb_first;
  endproperty
  a_srst_hold: assert property (p_srst_hold)
    else $error("write took effect during soft reset");

  property p_rd_order;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_rd_en |=> o_rd_vld && o_rd_data == ($past(o_lsb_first)
        ? scu_pkg::rev8($past(rd_val)) : $past(rd_val));
  endproperty
  a_rd_order: assert property (p_rd_order)
    else $error("read byte in wrong order");

  property p_addr_step;
    @(posedge i_clk) disable iff (i_sys_rst)
      byte_go && !cfg_wr |=> addr_cur == ($past(o_lsb_first)
        ? $past(addr_use) + 10'h001 : $past(addr_use) - 10'h001);
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address stepped the wrong way");

  property p_pin_mode;
    @(posedge i_clk) disable iff (i_sys_rst)
      cfg_wr && !cfg_hold |=>
        o_serial_read_out_pin_en == $past(wr_byte[0]);
  endproperty
  a_pin_mode: assert property (p_pin_mode)
    else $error("read pin mode not taken");

endmodule // scu_regs
